// file: dv/pgqs_top_tb.sv
`timescale 1ns/1ps
module pgqs_top_tb import pgqs_pkg::*; ;
  typedef struct packed {
    logic fab;
    logic tg;
    logic ct;
    logic [2:0] cos;
    logic [2:0] tc;
    logic mc;
    logic [2:0] exp;
  } pgqs_row_type;
  logic mclk, rst, in_valid, in_ready, in_mcast, in_tagged, in_ctrl, out_valid, out_ready;
  logic out_mcast, pg_wr, pg_wr_pfc, map_wr, map_active, adapter_link, cfg_error_clr;
  logic cfg_error, fabric_mode, remap_wr, lossless_wr, dscp_tc_wr, dscp_cos_wr, dscp_apply;
  logic dscp_reject, apply_error, dscp_trust, stall, slow, seen;
  logic [2:0] in_tc, in_cos, out_tc, map_wr_cos, remap_val, lossless_val, dscp_wr_val;
  logic [5:0] in_dscp, dscp_wr_idx;
  logic [LEN_W-1:0] in_len, out_len;
  logic [3:0] pg_wr_idx, map_wr_group;
  logic [7:0] pg_wr_bw;
  int err_count, comparisons, acc;
  // Lowest credible fill: queue depth less two slots, twice the one-slot ready margin
  localparam int DEPTH_LO = FIFO_DEPTH - 2;
  pgqs_row_type rows [5] = '{
    '{0, 1, 0, 3'h0, 3'h5, 1, 3'h5},
    '{0, 1, 0, 3'h1, 3'h4, 0, 3'h1},
    '{1, 0, 1, 3'h0, 3'h2, 0, 3'h7},
    '{1, 1, 0, 3'h7, 3'h6, 1, 3'h6},
    '{0, 1, 0, 3'h7, 3'h3, 0, 3'h3}};

  pgqs_top uut (.mclk, .rst, .in_valid, .in_ready, .in_tc, .in_cos, .in_dscp, .in_mcast,
    .in_tagged, .in_ctrl, .in_len, .out_valid, .out_ready, .out_tc, .out_mcast, .out_len,
    .pg_wr, .pg_wr_idx, .pg_wr_bw, .pg_wr_pfc, .map_wr, .map_wr_cos, .map_wr_group,
    .map_active, .adapter_link, .cfg_error_clr, .cfg_error, .fabric_mode, .remap_wr,
    .remap_val, .lossless_wr, .lossless_val, .dscp_tc_wr, .dscp_cos_wr, .dscp_wr_idx,
    .dscp_wr_val, .dscp_apply, .dscp_reject, .apply_error, .dscp_trust);
  pgqs_tx_model tx (.mclk, .rst, .out_valid, .out_ready, .out_tc, .out_mcast, .out_len,
    .stall, .slow);

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task automatic end_sim;
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic step(input int n);
    repeat (n) begin
      @(posedge mclk);
      #1;
    end
  endtask : step

  // Lowers valid a full cycle before the next offer, never in the same step
  task automatic send(input logic [2:0] tc, cos, input logic mc, tg, ct);
    int n;
    n = 0;
    {in_tc, in_cos, in_mcast, in_tagged, in_ctrl} = {tc, cos, mc, tg, ct};
    in_valid = 1'b1;
    while (in_ready !== 1'b1 && n < 50) begin
      step(1);
      n++;
    end
    if (n == 50) chk("in_ready", 16'h1, 16'(in_ready));
    step(1);
    in_valid = 1'b0;
    step(1);
  endtask : send

  task automatic expect_out(input logic [2:0] tc, input logic mc);
    int n;
    n = 0;
    while (tx.q_tc.size() == 0 && n < 100) begin
      step(1);
      n++;
    end
    chk("out_frame", 16'h1, 16'(tx.q_tc.size() != 0));
    if (tx.q_tc.size() != 0) begin
      chk("out_tc", 16'(tc), 16'(tx.q_tc.pop_front()));
      chk("out_mcast", 16'(mc), 16'(tx.q_mc.pop_front()));
      chk("out_len", 16'(in_len), 16'(tx.q_len.pop_front()));
    end
  endtask : expect_out

  task automatic wr_map(input logic [2:0] c, input logic [3:0] g);
    {map_wr_cos, map_wr_group} = {c, g};
    map_wr = 1'b1;
    step(1);
    map_wr = 1'b0;
    step(1);
  endtask : wr_map

  // Op bits: apply, cos map write, class map write
  task automatic dscp_op(input logic [2:0] op, input logic [5:0] i, input logic [2:0] v);
    {dscp_apply, dscp_cos_wr, dscp_tc_wr} = op;
    {dscp_wr_idx, dscp_wr_val} = {i, v};
    step(1);
    {dscp_apply, dscp_cos_wr, dscp_tc_wr} = 3'h0;
    seen = dscp_reject | apply_error;
    step(1);
    seen = seen | dscp_reject | apply_error;
  endtask : dscp_op

  initial begin
    #100000;
    err_count++;
    end_sim();
  end

  initial begin
    err_count = 0;
    comparisons = 0;
    rst = 1'b1;
    {in_valid, in_mcast, in_tagged, in_ctrl, pg_wr, pg_wr_pfc, map_wr, map_active} = '0;
    {adapter_link, cfg_error_clr, fabric_mode, remap_wr, lossless_wr, dscp_tc_wr} = '0;
    {dscp_cos_wr, dscp_apply, stall, slow, in_tc, in_cos, in_dscp, map_wr_cos} = '0;
    {remap_val, lossless_val, dscp_wr_val, dscp_wr_idx, pg_wr_idx, map_wr_group} = '0;
    pg_wr_bw = 8'h00;
    in_len = 14'h0040;
    step(3);
    chk("rst_outs", 16'h0, 16'({in_ready, out_valid, cfg_error, dscp_trust}));
    rst = 1'b0;
    step(2);
    chk("in_ready", 16'h1, 16'(in_ready));
    foreach (rows[k]) begin
      fabric_mode = rows[k].fab;
      send(rows[k].tc, rows[k].cos, rows[k].mc, rows[k].tg, rows[k].ct);
      expect_out(rows[k].exp, rows[k].mc);
    end
    remap_val = 3'h1;
    remap_wr = 1'b1;
    step(1);
    remap_wr = 1'b0;
    fabric_mode = 1'b1;
    send(3'h5, 3'h7, 1'b0, 1'b1, 1'b0);
    expect_out(3'h1, 1'b0);
    fabric_mode = 1'b0;
    // Strict frame overtakes a waiting round-robin frame
    stall = 1'b1;
    slow = 1'b1;
    wr_map(3'h2, 4'h0);
    send(3'h3, 3'h0, 1'b0, 1'b1, 1'b0);
    // Pointer idles round all classes; let it reach queue 3 before the strict frame lands
    step(8);
    send(3'h3, 3'h0, 1'b1, 1'b1, 1'b0);
    send(3'h4, 3'h2, 1'b0, 1'b1, 1'b0);
    stall = 1'b0;
    expect_out(3'h3, 1'b0);
    expect_out(3'h2, 1'b0);
    expect_out(3'h3, 1'b1);
    slow = 1'b0;
    wr_map(3'h2, 4'hA);
    {pg_wr_idx, pg_wr_bw, pg_wr_pfc} = {4'h8, 8'h0A, 1'b1};
    pg_wr = 1'b1;
    step(1);
    pg_wr = 1'b0;
    send(3'h5, 3'h0, 1'b0, 1'b1, 1'b0);
    expect_out(3'h0, 1'b0);
    wr_map(3'h3, 4'h8);
    chk("cfg_error", 16'h1, 16'(cfg_error));
    send(3'h5, 3'h0, 1'b0, 1'b1, 1'b0);
    expect_out(3'h5, 1'b0);
    cfg_error_clr = 1'b1;
    step(1);
    cfg_error_clr = 1'b0;
    step(1);
    chk("cfg_error", 16'h0, 16'(cfg_error));
    {map_active, adapter_link} = 2'b11;
    wr_map(3'h4, 4'h1);
    chk("cfg_error", 16'h0, 16'(cfg_error));
    wr_map(3'h5, 4'h2);
    chk("cfg_error", 16'h1, 16'(cfg_error));
    {map_active, adapter_link, cfg_error_clr} = 3'b001;
    step(1);
    cfg_error_clr = 1'b0;
    // Fill against a stalled transmitter, then drain it all
    stall = 1'b1;
    acc = 0;
    {in_tc, in_cos, in_mcast} = '0;
    in_valid = 1'b1;
    repeat (20) begin
      if (in_ready === 1'b1) acc++;
      step(1);
    end
    in_valid = 1'b0;
    chk("fill_limit", 16'h1, 16'(acc >= DEPTH_LO && acc <= FIFO_DEPTH + 1));
    chk("in_ready", 16'h0, 16'(in_ready));
    stall = 1'b0;
    repeat (acc) expect_out(3'h0, 1'b0);
    step(4);
    chk("drained", 16'h0, 16'({out_valid, !in_ready}));
    for (int f = 0; f < 2; f++) begin
      fabric_mode = f[0];
      for (int v = 0; v < 8; v++) begin
        dscp_op({2'b00, v[0]} ^ 3'h2, 6'h0, v[2:0]);
        chk("dscp_reject", 16'(f == 1 && (v == 3 || v == 7)), 16'(seen));
      end
    end
    lossless_val = 3'h4;
    lossless_wr = 1'b1;
    step(1);
    lossless_wr = 1'b0;
    dscp_op(3'h1, 6'h1, 3'h4);
    chk("dscp_reject", 16'h1, 16'(seen));
    dscp_op(3'h2, 6'h1, 3'h3);
    chk("dscp_reject", 16'h0, 16'(seen));
    dscp_op(3'h4, 6'h0, 3'h0);
    chk("apply_error", 16'h1, 16'(seen));
    chk("dscp_trust", 16'h0, 16'(dscp_trust));
    for (int d = 0; d < NUM_DSCP; d++) begin
      dscp_op(3'h1, 6'(d), 3'h1);
      dscp_op(3'h2, 6'(d), 3'h2);
    end
    dscp_op(3'h4, 6'h0, 3'h0);
    chk("apply_error", 16'h0, 16'(seen));
    chk("dscp_trust", 16'h1, 16'(dscp_trust));
    fabric_mode = 1'b0;
    in_dscp = 6'h09;
    send(3'h5, 3'h0, 1'b0, 1'b1, 1'b0);
    expect_out(3'h1, 1'b0);
    dscp_op(3'h1, 6'h0, 3'h1);
    chk("dscp_trust", 16'h0, 16'(dscp_trust));
    end_sim();
  end
endmodule : pgqs_top_tb

// file: dv/pgqs_tx_model.sv
`timescale 1ns/1ps
module pgqs_tx_model import pgqs_pkg::*; (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Scheduled frames
  input wire logic out_valid,
  output logic out_ready,
  input wire logic [2:0] out_tc,
  input wire logic out_mcast,
  input wire logic [LEN_W-1:0] out_len,
  // Test control
  input wire logic stall,
  input wire logic slow
);
  logic [2:0] q_tc[$];
  logic q_mc[$];
  logic [LEN_W-1:0] q_len[$];
  logic phase;
  // Slow mode refuses every other cycle so held frames get exercised
  assign out_ready = !stall && !(slow && phase);
  always_ff @(posedge mclk) begin
    if (rst) begin
      phase <= 1'b0;
    end else begin
      phase <= !phase;
    end
  end
  always @(posedge mclk) begin
    if (!rst && out_valid === 1'b1 && out_ready) begin
      q_tc.push_back(out_tc);
      q_mc.push_back(out_mcast);
      q_len.push_back(out_len);
    end
  end
endmodule : pgqs_tx_model

// file: verilog/pgqs_pkg.sv
package pgqs_pkg;
  localparam int NUM_TC = 8;
  localparam int NUM_PG = 16;
  localparam int NUM_SP = 8;
  localparam int NUM_DSCP = 64;
  localparam int FIFO_DEPTH = 8;
  localparam int LEN_W = 14;
  localparam int QUANTUM_UNIT = 64;
  localparam logic [2:0] TOP_TC = 3'h7;
  localparam logic [2:0] FABRIC_PRIO = 3'h7;
  localparam logic [2:0] REMAP_RESET = 3'h0;
  localparam logic [2:0] LOSSLESS_RESET = 3'h3;
  localparam logic [15:0] PFC_RESET = 16'h0201;
  localparam logic [7:0] BW_RESET = 8'h00;
  localparam logic [3:0] DEFICIT_WEIGHTED_ROUND_ROBIN_BASE = 4'h8;
  typedef enum logic [1:0] {
    PGQS_PICK = 2'b01,
    PGQS_SEND = 2'b10
  } pgqs_state_type;
endpackage : pgqs_pkg

// file: verilog/pgqs_top.sv
`timescale 1ns/1ps
module pgqs_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic mclk,
  input wire logic rst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic spare,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wptr;
  logic [AW-1:0] rptr;
  logic [AW:0] count;
  logic push;
  logic pop;
  assign in_ready = count != (AW+1)'(DEPTH);
  assign out_valid = count != '0;
  assign spare = count < (AW+1)'(DEPTH - 1);
  assign out_data = mem[rptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wptr] <= in_data;
    end
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      wptr <= '0;
      rptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wptr <= (wptr == AW'(DEPTH - 1)) ? '0 : wptr + 1'b1;
      end
      if (pop) begin
        rptr <= (rptr == AW'(DEPTH - 1)) ? '0 : rptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : pgqs_fifo

module pgqs_top import pgqs_pkg::*; #(
  parameter int DEPTH = FIFO_DEPTH,
  parameter int LW = LEN_W
) (
  input wire logic mclk,
  input wire logic rst,
  // Frame descriptors in
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [2:0] in_tc,
  input wire logic [2:0] in_cos,
  input wire logic [5:0] in_dscp,
  input wire logic in_mcast,
  input wire logic in_tagged,
  input wire logic in_ctrl,
  input wire logic [LW-1:0] in_len,
  // Scheduled frames to transmitter
  output logic out_valid,
  input wire logic out_ready,
  output logic [2:0] out_tc,
  output logic out_mcast,
  output logic [LW-1:0] out_len,
  // Group and priority tables
  input wire logic pg_wr,
  input wire logic [3:0] pg_wr_idx,
  input wire logic [7:0] pg_wr_bw,
  input wire logic pg_wr_pfc,
  input wire logic map_wr,
  input wire logic [2:0] map_wr_cos,
  input wire logic [3:0] map_wr_group,
  input wire logic map_active,
  input wire logic adapter_link,
  input wire logic cfg_error_clr,
  output logic cfg_error,
  // Fabric and DSCP
  input wire logic fabric_mode,
  input wire logic remap_wr,
  input wire logic [2:0] remap_val,
  input wire logic lossless_wr,
  input wire logic [2:0] lossless_val,
  input wire logic dscp_tc_wr,
  input wire logic dscp_cos_wr,
  input wire logic [5:0] dscp_wr_idx,
  input wire logic [2:0] dscp_wr_val,
  input wire logic dscp_apply,
  output logic dscp_reject,
  output logic apply_error,
  output logic dscp_trust
);
  localparam int DW = LW + 10;
  localparam int FW = LW + 1;
  logic [7:0] pg_bw [NUM_PG];
  logic [NUM_PG-1:0] pg_pfc;
  logic [3:0] cos_group [NUM_TC];
  logic [NUM_TC-1:0] cos_pfc;
  logic [2:0] remap_prio;
  logic [2:0] lossless_prio;
  logic [2:0] dscp_tc [NUM_DSCP];
  logic [2:0] dscp_cos [NUM_DSCP];
  logic tc_map_set;
  logic cos_map_set;
  logic map_bad;
  logic violation;
  logic [2:0] cls_tc;
  logic [2:0] cls_cos;
  logic push;
  logic [NUM_TC-1:0] q_valid;
  logic [NUM_TC-1:0] q_pop;
  logic [NUM_TC-1:0] q_spare;
  logic [FW-1:0] q_data [NUM_TC];
  pgqs_state_type state;
  logic [2:0] rr;
  logic signed [DW-1:0] deficit [NUM_TC];
  logic sp_any;
  logic [2:0] sp_tc;
  logic no_weight;
  logic [2:0] pick_tc;
  logic pick;

  // Flag of a class comes from its group; a queue's group is that of cos t
  always_comb begin
    for (int c = 0; c < NUM_TC; c++) begin
      cos_pfc[c] = pg_pfc[cos_group[c]];
    end
  end

  // Table checker
  always_comb begin
    int n;
    int sp_used;
    n = 0;
    sp_used = 0;
    violation = 1'b0;
    for (int g = 0; g < NUM_PG; g++) begin
      n = 0;
      for (int c = 0; c < NUM_TC; c++) begin
        n = n + int'(cos_group[c] == 4'(g));
      end
      if (pg_pfc[g] && n > 1) begin
        violation = 1'b1;
      end
      if (g < NUM_SP && n > 0) begin
        sp_used = sp_used + 1;
      end
    end
    if (map_active && adapter_link && sp_used > 1) begin
      violation = 1'b1;
    end
  end

  // Tables; a bad setup falls back to defaults on the next edge
  always_ff @(posedge mclk) begin
    if (rst || violation) begin
      pg_pfc <= PFC_RESET;
      for (int g = 0; g < NUM_PG; g++) begin
        pg_bw[g] <= BW_RESET;
      end
      for (int c = 0; c < NUM_TC; c++) begin
        cos_group[c] <= DEFICIT_WEIGHTED_ROUND_ROBIN_BASE + 4'(c);
      end
    end else begin
      if (pg_wr) begin
        pg_pfc[pg_wr_idx] <= pg_wr_pfc;
        pg_bw[pg_wr_idx] <= (pg_wr_idx < 4'(NUM_SP)) ? BW_RESET : pg_wr_bw;
      end
      if (map_wr) begin
        cos_group[map_wr_cos] <= map_wr_group;
      end
    end
  end

  // Set wins over clear
  always_ff @(posedge mclk) begin
    if (rst) begin
      cfg_error <= 1'b0;
    end else if (violation) begin
      cfg_error <= 1'b1;
    end else if (cfg_error_clr) begin
      cfg_error <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      remap_prio <= REMAP_RESET;
      lossless_prio <= LOSSLESS_RESET;
    end else begin
      if (remap_wr) begin
        remap_prio <= remap_val;
      end
      if (lossless_wr) begin
        lossless_prio <= lossless_val;
      end
    end
  end

  // Reserved or lossless values left anywhere in either map
  always_comb begin
    map_bad = 1'b0;
    for (int d = 0; d < NUM_DSCP; d++) begin
      if (dscp_tc[d] == TOP_TC || dscp_tc[d] == lossless_prio ||
          dscp_cos[d] == FABRIC_PRIO || dscp_cos[d] == lossless_prio) begin
        map_bad = 1'b1;
      end
    end
  end

  // DSCP maps start as plain precedence copies, which the fabric refuses
  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int d = 0; d < NUM_DSCP; d++) begin
        dscp_tc[d] <= 3'(d >> 3);
        dscp_cos[d] <= 3'(d >> 3);
      end
      tc_map_set <= 1'b0;
      cos_map_set <= 1'b0;
      dscp_reject <= 1'b0;
    end else begin
      dscp_reject <= 1'b0;
      if (dscp_tc_wr) begin
        if (fabric_mode && (dscp_wr_val == TOP_TC || dscp_wr_val == lossless_prio)) begin
          dscp_reject <= 1'b1;
        end else begin
          dscp_tc[dscp_wr_idx] <= dscp_wr_val;
          tc_map_set <= 1'b1;
        end
      end
      if (dscp_cos_wr) begin
        if (fabric_mode && (dscp_wr_val == FABRIC_PRIO || dscp_wr_val == lossless_prio)) begin
          dscp_reject <= 1'b1;
        end else begin
          dscp_cos[dscp_wr_idx] <= dscp_wr_val;
          cos_map_set <= 1'b1;
        end
      end
    end
  end

  // Trust stays off until both edited maps are applied clean
  always_ff @(posedge mclk) begin
    if (rst) begin
      dscp_trust <= 1'b0;
      apply_error <= 1'b0;
    end else begin
      apply_error <= 1'b0;
      if (dscp_tc_wr || dscp_cos_wr) begin
        dscp_trust <= 1'b0;
      end else if (dscp_apply) begin
        if (map_bad || !tc_map_set || !cos_map_set) begin
          apply_error <= 1'b1;
        end else begin
          dscp_trust <= 1'b1;
        end
      end
    end
  end

  // Classification; mutation and discard are outside this block
  always_comb begin
    cls_cos = in_cos;
    cls_tc = in_tc;
    if (fabric_mode && in_cos == FABRIC_PRIO) begin
      cls_cos = remap_prio;
    end
    if (dscp_trust) begin
      cls_cos = dscp_cos[in_dscp];
      cls_tc = dscp_tc[in_dscp];
    end
    if (cos_pfc[cls_cos]) begin
      cls_tc = cls_cos;
    end
    if (fabric_mode && in_ctrl && !in_tagged) begin
      cls_tc = TOP_TC;
    end
  end

  assign push = in_valid && in_ready;

  // One margin slot covers the frame accepted while ready updates
  always_ff @(posedge mclk) begin
    if (rst) begin
      in_ready <= 1'b0;
    end else begin
      in_ready <= &q_spare;
    end
  end

  genvar t;
  generate
    for (t = 0; t < NUM_TC; t++) begin : g_queue
      pgqs_fifo #(.WIDTH(FW), .DEPTH(DEPTH)) u_fifo (
        .mclk(mclk),
        .rst(rst),
        .in_valid(push && cls_tc == 3'(t)),
        .in_ready(),
        .in_data({in_mcast, in_len}),
        .spare(q_spare[t]),
        .out_valid(q_valid[t]),
        .out_ready(q_pop[t]),
        .out_data(q_data[t])
      );
    end
  endgenerate

  // Strict pick: lowest table index, then higher class
  always_comb begin
    logic [3:0] best;
    best = 4'hF;
    sp_any = 1'b0;
    sp_tc = 3'h0;
    no_weight = 1'b1;
    for (int i = NUM_TC - 1; i >= 0; i--) begin
      if (q_valid[i] && cos_group[i] < 4'(NUM_SP)) begin
        if (!sp_any || cos_group[i] < best) begin
          best = cos_group[i];
          sp_tc = 3'(i);
          sp_any = 1'b1;
        end
      end
      if (q_valid[i] && pg_bw[cos_group[i]] != 8'h00) begin
        no_weight = 1'b0;
      end
    end
  end

  // Zero-share queues move only when no weighted queue waits
  always_comb begin
    pick = 1'b0;
    pick_tc = rr;
    if (state == PGQS_PICK) begin
      if (sp_any) begin
        pick = 1'b1;
        pick_tc = sp_tc;
      end else if (q_valid[rr] && (deficit[rr] > 0 || no_weight)) begin
        pick = 1'b1;
      end
    end
    for (int i = 0; i < NUM_TC; i++) begin
      q_pop[i] = pick && pick_tc == 3'(i);
    end
  end

  // Deficit may go negative; that debt is repaid from later quanta unless the queue is found empty, which clears it
  always_ff @(posedge mclk) begin
    if (rst) begin
      rr <= 3'h7;
      for (int i = 0; i < NUM_TC; i++) begin
        deficit[i] <= '0;
      end
    end else if (state == PGQS_PICK && !sp_any) begin
      if (pick) begin
        deficit[rr] <= deficit[rr] - DW'(q_data[rr][LW-1:0]);
      end else begin
        if (q_valid[rr]) begin
          deficit[rr] <= deficit[rr] + DW'(pg_bw[cos_group[rr]]) * DW'(QUANTUM_UNIT);
        end else begin
          deficit[rr] <= '0;
        end
        rr <= rr - 3'h1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state <= PGQS_PICK;
      out_valid <= 1'b0;
      out_tc <= 3'h0;
      out_mcast <= 1'b0;
      out_len <= '0;
    end else begin
      case (state)
        PGQS_PICK: begin
          if (pick) begin
            out_valid <= 1'b1;
            out_tc <= pick_tc;
            out_mcast <= q_data[pick_tc][LW];
            out_len <= q_data[pick_tc][LW-1:0];
            state <= PGQS_SEND;
          end
        end
        PGQS_SEND: begin
          if (out_ready) begin
            out_valid <= 1'b0;
            state <= PGQS_PICK;
          end
        end
        default: state <= PGQS_PICK;
      endcase
    end
  end

  sequence s_bad_table;
    violation;
  endsequence
  sequence s_restored;
    cfg_error && pg_pfc == PFC_RESET;
  endsequence
  a_table_restore: assert property (@(posedge mclk) disable iff (rst)
    s_bad_table |=> s_restored) else $error("bad table not restored");
  a_strict_first: assert property (@(posedge mclk) disable iff (rst)
    pick && cos_group[pick_tc] >= 4'(NUM_SP) |-> !sp_any) else $error("rr before strict");
  a_out_hold: assert property (@(posedge mclk) disable iff (rst)
    out_valid && !out_ready |=> out_valid && $stable(out_tc) && $stable(out_len))
    else $error("output dropped");
  a_fabric_remap: assert property (@(posedge mclk) disable iff (rst)
    push && fabric_mode && !dscp_trust && in_cos == FABRIC_PRIO |-> cls_cos == remap_prio)
    else $error("priority 7 kept");
  a_ctrl_top: assert property (@(posedge mclk) disable iff (rst)
    push && fabric_mode && in_ctrl && !in_tagged |-> cls_tc == TOP_TC)
    else $error("control not in top class");
  a_pfc_force: assert property (@(posedge mclk) disable iff (rst)
    push && cos_pfc[cls_cos] && !(fabric_mode && in_ctrl && !in_tagged) |-> cls_tc == cls_cos)
    else $error("flow class not forced");
  a_tc_reject: assert property (@(posedge mclk) disable iff (rst)
    fabric_mode && dscp_tc_wr && dscp_wr_val == TOP_TC
    |=> dscp_reject && dscp_tc[$past(dscp_wr_idx)] == $past(dscp_tc[dscp_wr_idx]))
    else $error("class 7 entry taken");
  a_apply_refuse: assert property (@(posedge mclk) disable iff (rst)
    dscp_apply && !dscp_tc_wr && !dscp_cos_wr && map_bad |=> apply_error ##1 !apply_error)
    else $error("bad map applied");
endmodule : pgqs_top
